// [verilog/swpl_defines.vh]
// Shared constants for the single-wire PWM packet loader
`ifndef SWPL_DEFINES_VH
`define SWPL_DEFINES_VH

// Packet layout in the 32-bit serial shift register
`define SWPL_PKT_W        32
`define SWPL_CMD_MSB      31
`define SWPL_CMD_LSB      24
`define SWPL_CH0_MSB      23
`define SWPL_CH0_LSB      16
`define SWPL_CH1_MSB      15
`define SWPL_CH1_LSB      8
`define SWPL_CH2_MSB      7
`define SWPL_CH2_LSB      0
`define SWPL_LVL_W        24
`define SWPL_CMD_WRITE    8'h3A

// Reset values
`define SWPL_SHREG_RST    32'h00000000
`define SWPL_LEVEL_RST    8'h00
`define SWPL_PWM_RST      8'h00

// Idle intervals as left shifts of the measured bit period
`define SWPL_EOS_SHIFT    2
`define SWPL_LAT_SHIFT    3

// Timing: clock period and accepted bit period range, in ns
`define SWPL_CLK_NS       20
`define SWPL_MIN_BIT_NS   1660
`define SWPL_MAX_BIT_NS   50000
`define SWPL_MIN_BIT_CYC  ((`SWPL_MIN_BIT_NS + `SWPL_CLK_NS - 1) / `SWPL_CLK_NS)
`define SWPL_MAX_BIT_CYC  (`SWPL_MAX_BIT_NS / `SWPL_CLK_NS)

// Default divider from the system clock to the grayscale clock
`define SWPL_GS_DIV       8

`endif

// [verilog/swpl_fifo.v]
// Synchronous valid/ready FIFO carrying committed channel levels
`timescale 1ns/1ns
module swpl_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock, reset, enable
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             en_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = en_i & in_valid_i & in_ready_o;
  wire pop  = en_i & out_valid_o & out_ready_i;

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_ptr_q];

  // Storage has no reset; only the pointers and the count carry control state
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers are AW bits wide and wrap at 2**AW, so DEPTH must equal 2**AW
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [verilog/swpl_loader.v]
// Single-wire packet receiver, commit logic and 3-channel PWM generator
`timescale 1ns/1ns
`include "swpl_defines.vh"
module swpl_loader #(
  parameter CNT_W      = 16,
  parameter GS_DIV     = `SWPL_GS_DIV,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // Clock, reset and enable
  input  wire             mclk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  // Serial link
  input  wire             serial_line_in_i,
  output reg              serial_line_out_o,
  // Sink outputs, high means the channel sinks current
  output reg  [2:0]       sink_output_o,
  // Status
  output reg  [7:0]       channel0_level_o,
  output reg  [7:0]       channel1_level_o,
  output reg  [7:0]       channel2_level_o,
  output reg  [CNT_W-1:0] measured_bit_period_o,
  output reg              packet_end_marker_o
);

  // Receiver states
  localparam [3:0] ST_WAIT1 = 4'b0001;
  localparam [3:0] ST_WAIT2 = 4'b0010;
  localparam [3:0] ST_SHIFT = 4'b0100;
  localparam [3:0] ST_PASS  = 4'b1000;

  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam integer     GS_LAST_I = GS_DIV - 1;
  localparam [7:0]       GS_LAST   = GS_LAST_I[7:0];

  // Channel is on from count one while the count does not exceed its level
  function chan_on;
    input [7:0] cnt;
    input [7:0] lvl;
    begin
      chan_on = (cnt != 8'h00) && (cnt <= lvl);
    end
  endfunction

  // Saturating increment keeps idle counters from wrapping on long gaps
  function [CNT_W-1:0] sat_inc;
    input [CNT_W-1:0] v;
    begin
      sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
    end
  endfunction

  // Input synchroniser and edge history
  reg                      sync1_q;
  reg                      sync2_q;
  reg                      sync3_q;
  // Receiver state
  reg  [3:0]               state_q;
  reg  [CNT_W-1:0]         bit_tmr_q;
  reg  [CNT_W-1:0]         low_cnt_q;
  reg  [CNT_W-1:0]         period_q;
  reg                      bit_open_q;
  reg                      bit_one_q;
  reg  [`SWPL_PKT_W-1:0]   shreg_q;
  // Commit hand-off toward the FIFO
  reg                      push_pend_q;
  reg  [`SWPL_LVL_W-1:0]   push_data_q;
  // PWM side
  reg  [7:0]               gs_div_q;
  reg  [7:0]               pwm_cnt_q;
  reg  [7:0]               lvl0_q;
  reg  [7:0]               lvl1_q;
  reg  [7:0]               lvl2_q;

  wire                     fifo_in_ready;
  wire                     fifo_out_valid;
  wire [`SWPL_LVL_W-1:0]   fifo_out_data;

  // Only the second and third flops are looked at, never the first
  wire rise      = sync2_q & ~sync3_q;
  wire line_low  = ~sync2_q;
  wire [CNT_W-1:0] half_per = period_q >> 1;
  wire [CNT_W-1:0] eos_len  = period_q << `SWPL_EOS_SHIFT;
  wire [CNT_W-1:0] lat_len  = period_q << `SWPL_LAT_SHIFT;

  // Idle detection is armed only once a period has been measured
  wire measured  = (state_q == ST_SHIFT) || (state_q == ST_PASS);
  wire eos_hit   = (state_q == ST_SHIFT) && line_low && (low_cnt_q == eos_len);
  wire lat_hit   = measured && line_low && (low_cnt_q == lat_len);
  wire cmd_ok    = (shreg_q[`SWPL_CMD_MSB:`SWPL_CMD_LSB] == `SWPL_CMD_WRITE);
  wire bit_close = bit_open_q && (bit_tmr_q == half_per);
  wire bit_new   = rise && (!bit_open_q || (bit_tmr_q >= half_per));
  wire gs_tick   = (gs_div_q == GS_LAST);
  wire load      = gs_tick & fifo_out_valid;

  // Two flops on the pin plus one more for the edge detector
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= serial_line_in_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Low-time counter measures both idle intervals
  always @(posedge mclk_i) begin
    if (rst_i) begin
      low_cnt_q <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      if (!line_low) begin
        low_cnt_q <= {CNT_W{1'b0}};
      end else begin
        low_cnt_q <= sat_inc(low_cnt_q);
      end
    end
  end

  // Receiver: period measurement, bit decode, lock and pass-through
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_q    <= ST_WAIT1;
      bit_tmr_q  <= {CNT_W{1'b0}};
      period_q   <= {CNT_W{1'b0}};
      bit_open_q <= 1'b0;
      bit_one_q  <= 1'b0;
      shreg_q    <= `SWPL_SHREG_RST;
    end else if (ce_i) begin
      bit_tmr_q <= sat_inc(bit_tmr_q);
      case (state_q)
        ST_WAIT1: begin
          bit_open_q <= 1'b0;
          if (rise) begin
            bit_tmr_q <= {CNT_W{1'b0}};
            state_q   <= ST_WAIT2;
          end
        end
        ST_WAIT2: begin
          // Gap between the first two edges becomes the bit period
          if (rise) begin
            period_q   <= sat_inc(bit_tmr_q);
            shreg_q    <= {shreg_q[`SWPL_PKT_W-2:0], 1'b0};
            bit_tmr_q  <= {CNT_W{1'b0}};
            bit_open_q <= 1'b1;
            bit_one_q  <= 1'b0;
            state_q    <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (lat_hit) begin
            bit_open_q <= 1'b0;
            state_q    <= ST_WAIT1;
          end else if (eos_hit) begin
            bit_open_q <= 1'b0;
            state_q    <= ST_PASS;
          end else begin
            // A closing bit and a new start may meet in the same cycle
            if (bit_close) begin
              shreg_q <= {shreg_q[`SWPL_PKT_W-2:0], bit_one_q};
            end
            if (bit_new) begin
              bit_tmr_q  <= {CNT_W{1'b0}};
              bit_open_q <= 1'b1;
              bit_one_q  <= 1'b0;
            end else if (rise) begin
              bit_one_q  <= 1'b1;
            end else if (bit_close) begin
              bit_open_q <= 1'b0;
            end
          end
        end
        ST_PASS: begin
          // Shift register stays frozen; only the commit idle ends this
          if (lat_hit) begin
            state_q <= ST_WAIT1;
          end
        end
        default: begin
          state_q <= ST_WAIT1;
        end
      endcase
    end
  end

  // Commit request waits here while the FIFO is full; a newer commit
  // replaces an unaccepted one, since only the latest levels matter
  always @(posedge mclk_i) begin
    if (rst_i) begin
      push_pend_q <= 1'b0;
      push_data_q <= {`SWPL_LVL_W{1'b0}};
    end else if (ce_i) begin
      if (lat_hit && cmd_ok) begin
        push_pend_q <= 1'b1;
        push_data_q <= shreg_q[`SWPL_CH0_MSB:`SWPL_CH2_LSB];
      end else if (fifo_in_ready) begin
        push_pend_q <= 1'b0;
      end
    end
  end

  swpl_fifo #(
    .WIDTH (`SWPL_LVL_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (mclk_i),
    .rst_i       (rst_i),
    .en_i        (ce_i),
    .in_valid_i  (push_pend_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (gs_tick),
    .out_data_o  (fifo_out_data)
  );

  // Grayscale clock divider; levels are only taken on its tick
  always @(posedge mclk_i) begin
    if (rst_i) begin
      gs_div_q <= 8'h00;
    end else if (ce_i) begin
      if (gs_tick) begin
        gs_div_q <= 8'h00;
      end else begin
        gs_div_q <= gs_div_q + 8'h01;
      end
    end
  end

  // Level latch and PWM counter
  always @(posedge mclk_i) begin
    if (rst_i) begin
      lvl0_q    <= `SWPL_LEVEL_RST;
      lvl1_q    <= `SWPL_LEVEL_RST;
      lvl2_q    <= `SWPL_LEVEL_RST;
      pwm_cnt_q <= `SWPL_PWM_RST;
    end else if (ce_i) begin
      if (load) begin
        lvl0_q    <= fifo_out_data[`SWPL_CH0_MSB:`SWPL_CH0_LSB];
        lvl1_q    <= fifo_out_data[`SWPL_CH1_MSB:`SWPL_CH1_LSB];
        lvl2_q    <= fifo_out_data[`SWPL_CH2_MSB:`SWPL_CH2_LSB];
        pwm_cnt_q <= `SWPL_PWM_RST;
      end else if (gs_tick) begin
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end
    end
  end

  // Registered sink outputs, forced off in the load cycle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sink_output_o <= 3'b000;
    end else if (ce_i) begin
      if (load) begin
        sink_output_o <= 3'b000;
      end else begin
        sink_output_o[0] <= chan_on(pwm_cnt_q, lvl0_q);
        sink_output_o[1] <= chan_on(pwm_cnt_q, lvl1_q);
        sink_output_o[2] <= chan_on(pwm_cnt_q, lvl2_q);
      end
    end
  end

  // Pass-through to the next device and status mirrors
  always @(posedge mclk_i) begin
    if (rst_i) begin
      serial_line_out_o     <= 1'b0;
      packet_end_marker_o   <= 1'b0;
      channel0_level_o      <= `SWPL_LEVEL_RST;
      channel1_level_o      <= `SWPL_LEVEL_RST;
      channel2_level_o      <= `SWPL_LEVEL_RST;
      measured_bit_period_o <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      // Output is low unless locked, so the next device sees idle
      serial_line_out_o     <= (state_q == ST_PASS) & sync2_q;
      packet_end_marker_o   <= (state_q == ST_PASS);
      channel0_level_o      <= lvl0_q;
      channel1_level_o      <= lvl1_q;
      channel2_level_o      <= lvl2_q;
      measured_bit_period_o <= period_q;
    end
  end

endmodule

// [tb/swpl_loader_monitor.sv]
// Port-level assertions for the packet loader
`timescale 1ns/1ns
module swpl_loader_monitor #(
  parameter CNT_W  = 16,
  parameter GS_DIV = 8
) (
  // Clock and reset
  input logic             mclk_i,
  input logic             rst_i,
  input logic             ce_i,
  // Serial link
  input logic             serial_line_in_i,
  input logic             serial_line_out_o,
  // Outputs and status
  input logic [2:0]       sink_output_o,
  input logic [7:0]       channel0_level_o,
  input logic [7:0]       channel1_level_o,
  input logic [7:0]       channel2_level_o,
  input logic [CNT_W-1:0] measured_bit_period_o,
  input logic             packet_end_marker_o
);
  localparam int ON_MAX = GS_DIV + 4;
  logic [19:0] low_q;
  logic [11:0] run_q;
  default clocking @(posedge mclk_i); endclocking
  // A low enable freezes the design, so checks pause with it
  default disable iff (rst_i || !ce_i);
  // Pin low run and channel 0 on run; both hold while the enable is low
  always @(posedge mclk_i) begin
    if (rst_i) begin
      low_q <= 20'h00000;
      run_q <= 12'h000;
    end else if (ce_i) begin
      low_q <= serial_line_in_i ? 20'h00000 : low_q + {19'h00000, low_q != 20'hFFFFF};
      run_q <= sink_output_o[0] ? run_q + 12'h001 : 12'h000;
    end
  end
  // A level load and the dark stretch that must follow it
  sequence s_load;
    !$stable({channel0_level_o, channel1_level_o, channel2_level_o});
  endsequence
  sequence s_dark;
    (sink_output_o == 3'h0) [*6];
  endsequence
  AST_RESET_QUIET: assert property (
    $past(rst_i) |-> sink_output_o == 3'h0 && !packet_end_marker_o && channel0_level_o == 8'h00)
    else $error("outputs active after reset");
  AST_OUT_IDLE_LOW: assert property (!packet_end_marker_o |-> !serial_line_out_o)
    else $error("serial out driven while unlocked");
  AST_OUT_MIRROR: assert property (
    packet_end_marker_o && $past(packet_end_marker_o) |->
      serial_line_out_o == $past(serial_line_in_i, 3))
    else $error("serial out not a copy of the input");
  AST_LOCK_ON_IDLE: assert property (
    measured_bit_period_o != 0 && low_q == (measured_bit_period_o << 2) + 8 |->
      packet_end_marker_o)
    else $error("no lock after end-of-packet idle");
  AST_LOAD_ONLY_ON_COMMIT: assert property (
    s_load |-> low_q > (measured_bit_period_o << 3))
    else $error("levels changed without commit idle");
  AST_DARK_AFTER_LOAD: assert property (s_load |-> s_dark)
    else $error("outputs not forced off at load");
  AST_ON_AFTER_LOAD: assert property (
    !$stable(channel0_level_o) && channel0_level_o != 8'h00 |-> ##[1:ON_MAX] sink_output_o[0])
    else $error("channel 0 did not turn on after load");
  AST_ON_TIME_BOUND: assert property (run_q <= channel0_level_o * GS_DIV)
    else $error("channel 0 on longer than its level");
endmodule
bind swpl_loader swpl_loader_monitor #(.CNT_W(CNT_W), .GS_DIV(GS_DIV)) swpl_loader_monitor_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .serial_line_in_i(serial_line_in_i),
  .serial_line_out_o(serial_line_out_o), .sink_output_o(sink_output_o),
  .channel0_level_o(channel0_level_o), .channel1_level_o(channel1_level_o),
  .channel2_level_o(channel2_level_o), .measured_bit_period_o(measured_bit_period_o),
  .packet_end_marker_o(packet_end_marker_o));

// [tb/swpl_sender.sv]
// Behavioural upstream sender driving the single-wire link
`timescale 1ns/1ns
module swpl_sender (
  // Clock
  input  wire clk_i,
  // Serial line toward the loader, idle low
  output reg  line_o
);
  int per = 100; // Bit period in clock cycles, kept within 1.66 to 50 us
  initial line_o = 1'b0;
  // One bit: rise at start; a second rise at a quarter period makes it a one
  task automatic send_bit(input bit b);
    for (int c = 0; c < per; c++) begin
      @(negedge clk_i);
      line_o = (c < 2) || (b && c >= per / 4 && c < per / 4 + 2);
    end
  endtask
  // Whole packet MSB first at one period; the loader does not count bits
  task automatic send_pkt(input logic [31:0] pkt);
    for (int i = 31; i >= 0; i--)
      send_bit(pkt[i]);
  endtask
  // Low idle: a short one ends a packet, a long one commits
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i) line_o = 1'b0;
  endtask
endmodule

// [tb/single_wire_pwm_packet_loader_tb.sv]
// Self-checking bench for the single-wire PWM packet loader
`timescale 1ns/1ns
module single_wire_pwm_packet_loader_tb;
  localparam GS_DIV = 8;
  // Design signals
  reg          mclk_i;
  reg          rst_i;
  reg          ce_i;
  wire         serial_line_in_i;
  wire         serial_line_out_o;
  wire [2:0]   sink_output_o;
  wire [7:0]   channel0_level_o;
  wire [7:0]   channel1_level_o;
  wire [7:0]   channel2_level_o;
  wire [15:0]  measured_bit_period_o;
  wire         packet_end_marker_o;
  // Bench state
  int          fail_count;
  int          n_checks;
  logic [23:0] exp_lv;
  int          out_rises = 0;
  logic        out_prev  = 1'b0;
  swpl_loader #(.GS_DIV(GS_DIV)) swpl_loader_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .serial_line_in_i(serial_line_in_i),
    .serial_line_out_o(serial_line_out_o), .sink_output_o(sink_output_o),
    .channel0_level_o(channel0_level_o), .channel1_level_o(channel1_level_o),
    .channel2_level_o(channel2_level_o), .measured_bit_period_o(measured_bit_period_o),
    .packet_end_marker_o(packet_end_marker_o));
  swpl_sender swpl_sender_inst (.clk_i(mclk_i), .line_o(serial_line_in_i));
  // Rises on the pass-through output, sampled where the output is settled
  always @(negedge mclk_i) begin
    out_rises += (serial_line_out_o === 1'b1 && out_prev !== 1'b1);
    out_prev = serial_line_out_o;
  end
  // 50 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // Compare helpers
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_duty(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for the pass-through lock
  task automatic wait_lock(input int lim);
    int i;
    for (i = 0; i < lim && packet_end_marker_o !== 1'b1; i++) @(negedge mclk_i);
    chk_val("lock", 1, packet_end_marker_o);
    if (i == lim) finish_test;
  endtask
  // Expected lit cycles per frame: counts one to the level, each one divider long
  function automatic int exp_on(input logic [7:0] lvl);
    return lvl * GS_DIV;
  endfunction
  // Expected rises of a passed packet: one per bit plus the extra pulse of a one
  function automatic int exp_rises(input logic [31:0] pkt);
    return 32 + $countones(pkt);
  endfunction
  // One full PWM frame with an enable-low stretch inside it
  task automatic chk_pwm;
    int on [3] = '{0, 0, 0};
    int n = 0;
    int stop_at;
    int hold;
    stop_at = 100 + $urandom % 1800;
    hold = 20 + $urandom % 60;
    while (n < 256 * GS_DIV) begin
      @(negedge mclk_i);
      // Only cycles the enable let through advance the design, so only those count
      if (ce_i) begin
        n++;
        for (int i = 0; i < 3; i++) on[i] += (sink_output_o[i] === 1'b1);
      end
      if (n == stop_at && hold > 0) begin
        ce_i = 1'b0;
        hold--;
      end else begin
        ce_i = 1'b1;
      end
    end
    chk_duty("on0", exp_on(exp_lv[23:16]), on[0]);
    chk_duty("on1", exp_on(exp_lv[15:8]), on[1]);
    chk_duty("on2", exp_on(exp_lv[7:0]), on[2]);
  endtask
  // Long idle commits; margin covers sync delay and the grayscale tick
  task automatic commit_check(input int per);
    swpl_sender_inst.idle(8 * per + 40);
    chk_val("marker", 0, packet_end_marker_o);
    chk_val("out idle", 0, serial_line_out_o);
    chk_val("levels", exp_lv, {channel0_level_o, channel1_level_o, channel2_level_o});
    chk_pwm;
  endtask
  // Main sequence
  initial begin
    int per;
    logic [7:0] cmd;
    logic [23:0] dat;
    logic [31:0] pass_pkt;
    int rises0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    fail_count = 0;
    n_checks = 0;
    exp_lv = 24'h000000;
    void'($urandom(88));
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (40) @(negedge mclk_i);
    chk_val("sink", 0, sink_output_o);
    chk_val("levels", 0, {channel0_level_o, channel1_level_o, channel2_level_o});
    for (int k = 0; k < 6; k++) begin
      per = 84 + $urandom % 80;
      dat = (k == 0) ? 24'hFF0001 : 24'($urandom);
      // Wrong commands keep the leading zero the period measurement needs
      cmd = (k == 2 || k == 4) ? 8'($urandom % 58) : 8'h3A;
      swpl_sender_inst.per = per;
      swpl_sender_inst.send_pkt({cmd, dat});
      chk_val("period", per, measured_bit_period_o);
      if (cmd == 8'h3A) exp_lv = dat;
      if (k == 3) begin
        wait_lock(5 * per + 20);
        pass_pkt = $urandom;
        rises0 = out_rises;
        swpl_sender_inst.send_pkt(pass_pkt);
        chk_duty("out rises", exp_rises(pass_pkt), out_rises - rises0);
      end
      commit_check(per);
    end
    finish_test;
  end
  // Hang guard
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
endmodule
